// *** tv_encoder_pkg.sv ***
// Purpose: shared constants and carriers for the vga to tv encoder core
// Assumes: single 10 MHz clock domain
// Notes: mode table values are per operating mode code
package tv_encoder_pkg;
	localparam int PIXEL_WIDTH = 8;
	localparam int MODE_WIDTH = 3;
	localparam logic [2:0] MODE_POWER_DOWN = 3'h7;
	localparam logic [2:0] MODE_RESET = 3'h1;
	localparam int CLOCK_HZ = 10000000;
	localparam real CRYSTAL_MHZ = 14.31818;
	// subcarrier phase step per crystal tick, 32-bit accumulator
	localparam logic [31:0] NTSC_CARRIER_STEP = 32'h40000000;
	localparam logic [31:0] PAL_CARRIER_STEP = 32'h4f5c28f6;
	localparam int LINE_DEPTH = 1024;
	localparam logic [10:0] NTSC_TV_LINES = 11'h20d;
	localparam logic [10:0] PAL_TV_LINES = 11'h271;
	localparam logic [7:0] HSYNC_WIDTH = 8'h2f;
	localparam logic [7:0] BURST_START = 8'h3a;
	localparam logic [7:0] BURST_WIDTH = 8'h24;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} rgb_s;

	typedef struct packed {
		logic [7:0] luma;
		logic [7:0] chroma;
	} yc_s;

	typedef struct packed {
		logic isPal;
		logic is800;
		logic underscan;
		logic [2:0] scaleNum;
		logic [2:0] scaleDen;
	} mode_cfg_s;
endpackage : tv_encoder_pkg

// *** tv_encoder_core.sv ***
// Purpose: digital pipeline from sampled vga rgb to composite and s-video codes
// Assumes: pixel strobe comes from the external pll or external clock path
// Notes: analog converters, pll loop and dac references live outside
`timescale 1ns/1ps
`default_nettype none

module tv_encoder_core #(
	parameter int LINE_DEPTH = tv_encoder_pkg::LINE_DEPTH
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic pllPixelStrobe,
	input wire logic external_pixel_clock_in,
	input wire logic useExternalClock,
	input wire logic crystalTick,
	input wire logic vgaHsync,
	input wire logic vgaVsync,
	input wire tv_encoder_pkg::rgb_s adcPixel,
	input wire logic programming_mode_select,
	input wire logic [2:0] display_mode_pins,
	input wire logic [2:0] serialMode,
	input wire logic serialPowerDown,
	output logic [7:0] dacComposite,
	output logic [7:0] dacLuma,
	output logic [7:0] dacChroma,
	output logic tvSync,
	output logic burstGate,
	output logic powerDown,
	output logic [2:0] activeMode
);
	localparam int AW = $clog2(LINE_DEPTH);

	typedef enum logic [1:0] {IDLE, FILL, RUN} line_state_e;

	logic [2:0] mode_reg, mode_next;
	logic powerDown_reg, powerDown_next;
	tv_encoder_pkg::mode_cfg_s cfg;
	logic extClk_reg, extClk_next;
	logic pixStrobe;
	tv_encoder_pkg::rgb_s pix_reg, pix_next;
	logic pixValid_reg, pixValid_next;
	logic [7:0] yVal, uVal, vVal;
	logic chromaPhase_reg, chromaPhase_next;
	logic [AW-1:0] wrAddr_reg, wrAddr_next;
	logic [AW-1:0] rdAddr_reg, rdAddr_next;
	logic [2:0] scaleAcc_reg, scaleAcc_next;
	logic [AW-1:0] lineLen_reg, lineLen_next;
	line_state_e lineState_reg, lineState_next;
	logic [1:0] bank_reg, bank_next;
	tv_encoder_pkg::yc_s lineMem [3][LINE_DEPTH];
	tv_encoder_pkg::yc_s tap0, tap1, tap2;
	logic [9:0] filtLuma;
	logic [7:0] aaLuma_reg, aaLuma_next;
	logic [7:0] prevLuma_reg, prevLuma_next;
	logic [31:0] carrier_reg, carrier_next;
	logic hsyncDly_reg, vsyncDly_reg;
	logic hsyncRise;
	logic [10:0] tvLine_reg, tvLine_next;
	logic [7:0] lineCount_reg, lineCount_next;
	logic tvPhase_reg, tvPhase_next;
	logic [7:0] comp_reg, comp_next, luma_reg, luma_next, chroma_reg, chroma_next;
	logic sync_reg, sync_next, burst_reg, burst_next;
	logic [8:0] chromaMod;

	// mode source and power-down selection
	always_comb begin
		mode_next = mode_reg;
		powerDown_next = powerDown_reg;
		if (programming_mode_select) begin
			if (serialMode != tv_encoder_pkg::MODE_POWER_DOWN)
				mode_next = serialMode;
			powerDown_next = serialPowerDown;
		end else begin
			powerDown_next = (display_mode_pins == tv_encoder_pkg::MODE_POWER_DOWN);
			if (display_mode_pins != tv_encoder_pkg::MODE_POWER_DOWN)
				mode_next = display_mode_pins;
		end
		extClk_next = useExternalClock;
	end

	// mode decode; code 7 never latches, default keeps the synthesiser honest
	always_comb begin
		cfg = '0;
		unique case (mode_reg)
			3'h0: cfg = '{1'b1, 1'b1, 1'b1, 3'h5, 3'h6};
			3'h1: cfg = '{1'b1, 1'b0, 1'b1, 3'h1, 3'h1};
			3'h2: cfg = '{1'b0, 1'b0, 1'b0, 3'h1, 3'h1};
			3'h3: cfg = '{1'b0, 1'b0, 1'b1, 3'h7, 3'h0};
			3'h4: cfg = '{1'b1, 1'b0, 1'b0, 3'h1, 3'h1};
			3'h5: cfg = '{1'b1, 1'b1, 1'b0, 3'h1, 3'h1};
			3'h6: cfg = '{1'b0, 1'b1, 1'b1, 3'h3, 3'h4};
			default: cfg = '{1'b1, 1'b0, 1'b1, 3'h1, 3'h1};
		endcase
	end

	// external clock is sampled as an ordinary pixel strobe
	assign pixStrobe = extClk_reg ? external_pixel_clock_in : pllPixelStrobe;

	always_comb begin
		pix_next = pix_reg;
		pixValid_next = 1'b0;
		if (pixStrobe && !powerDown_reg) begin
			pix_next = adcPixel;
			pixValid_next = 1'b1;
		end
	end

	// integer bt.601-style matrix, constant multiplies with the top byte kept as a divide by 256
	always_comb begin
		logic [15:0] y16, u16, v16;
		y16 = 16'(77 * pix_reg.red) + 16'(150 * pix_reg.green) + 16'(29 * pix_reg.blue);
		u16 = 16'h8000 + 16'(128 * pix_reg.blue) - 16'(43 * pix_reg.red) - 16'(85 * pix_reg.green);
		v16 = 16'h8000 + 16'(128 * pix_reg.red) - 16'(107 * pix_reg.green) - 16'(21 * pix_reg.blue);
		yVal = y16[15:8];
		uVal = u16[15:8];
		vVal = v16[15:8];
	end

	assign hsyncRise = vgaHsync && !hsyncDly_reg;

	// write side fills one bank per vga line, read side walks with scaling
	always_comb begin
		wrAddr_next = wrAddr_reg;
		chromaPhase_next = chromaPhase_reg;
		lineState_next = lineState_reg;
		bank_next = bank_reg;
		lineLen_next = lineLen_reg;
		rdAddr_next = rdAddr_reg;
		scaleAcc_next = scaleAcc_reg;
		if (pixValid_reg) begin
			wrAddr_next = AW'(wrAddr_reg + 1'b1);
			chromaPhase_next = !chromaPhase_reg;
		end
		if (hsyncRise) begin
			lineLen_next = wrAddr_reg;
			wrAddr_next = '0;
			chromaPhase_next = 1'b0;
			rdAddr_next = '0;
			bank_next = (bank_reg == 2'h2) ? 2'h0 : 2'(bank_reg + 1'b1);
			unique case (lineState_reg)
				IDLE: lineState_next = FILL;
				FILL: lineState_next = RUN;
				RUN: lineState_next = RUN;
			endcase
		end else if (lineState_reg == RUN && rdAddr_reg != lineLen_reg) begin
			// underscan skips one pixel each time scaleAcc reaches num; equal num/den skips none
			rdAddr_next = AW'(rdAddr_reg + 1'b1);
			if (cfg.underscan && scaleAcc_reg >= cfg.scaleNum) begin
				scaleAcc_next = '0;
				// never skip past the line end, the walk would then run the whole buffer
				if (cfg.scaleNum != cfg.scaleDen && rdAddr_next != lineLen_reg)
					rdAddr_next = AW'(rdAddr_reg + 2'h2);
			end else begin
				scaleAcc_next = 3'(scaleAcc_reg + 1'b1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (pixValid_reg)
			lineMem[bank_reg][wrAddr_reg] <= '{yVal, chromaPhase_reg ? vVal : uVal};
	end

	// three adjacent lines feed the 1:2:1 vertical filter in underscan modes; other modes pass tap1 alone
	always_comb begin
		tap0 = lineMem[0][rdAddr_reg];
		tap1 = lineMem[1][rdAddr_reg];
		tap2 = lineMem[2][rdAddr_reg];
		filtLuma = 10'(tap0.luma) + 10'(tap2.luma) + {1'b0, tap1.luma, 1'b0};
		if (!cfg.underscan)
			filtLuma = {tap1.luma, 2'b00};
	end

	// two-tap anti-alias average before encoding
	always_comb begin
		prevLuma_next = filtLuma[9:2];
		aaLuma_next = 8'((9'(filtLuma[9:2]) + 9'(prevLuma_reg)) >> 1);
	end

	// subcarrier advances only on crystal ticks
	always_comb begin
		carrier_next = carrier_reg;
		if (crystalTick)
			carrier_next = carrier_reg + (cfg.isPal ? tv_encoder_pkg::PAL_CARRIER_STEP
				: tv_encoder_pkg::NTSC_CARRIER_STEP);
	end

	// tv line counter: two vga lines per tv line, frame length per standard
	always_comb begin
		tvPhase_next = tvPhase_reg;
		tvLine_next = tvLine_reg;
		// saturate without blocking the line-start clear below
		lineCount_next = (lineCount_reg == 8'hff) ? lineCount_reg : 8'(lineCount_reg + 1'b1);
		if (hsyncRise) begin
			tvPhase_next = !tvPhase_reg;
			if (tvPhase_reg) begin
				lineCount_next = '0;
				if (tvLine_reg == (cfg.isPal ? tv_encoder_pkg::PAL_TV_LINES
					: tv_encoder_pkg::NTSC_TV_LINES) - 11'h1)
					tvLine_next = '0;
				else
					tvLine_next = 11'(tvLine_reg + 1'b1);
			end
		end
		if (vgaVsync && !vsyncDly_reg)
			tvLine_next = '0;
	end

	always_comb begin
		// first tv line of a frame is held in sync as the vertical interval, no burst there
		sync_next = (tvLine_reg == 11'h0) ||
			(lineCount_reg < tv_encoder_pkg::HSYNC_WIDTH);
		burst_next = (tvLine_reg != 11'h0) &&
			(lineCount_reg >= tv_encoder_pkg::BURST_START) &&
			(lineCount_reg < 8'(tv_encoder_pkg::BURST_START + tv_encoder_pkg::BURST_WIDTH));
		chromaMod = carrier_reg[31] ? 9'(tap1.chroma) : 9'(9'h100 - 9'(tap1.chroma));
		luma_next = sync_next ? 8'h00 : aaLuma_reg;
		chroma_next = burst_next ? (carrier_reg[31] ? 8'hc0 : 8'h40) : chromaMod[7:0];
		comp_next = 8'((9'(luma_next) + 9'(chroma_next)) >> 1);
		if (powerDown_reg) begin
			luma_next = '0;
			chroma_next = '0;
			comp_next = '0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_reg <= tv_encoder_pkg::MODE_RESET;
			powerDown_reg <= 1'b0;
			extClk_reg <= 1'b0;
			pix_reg <= '0;
			pixValid_reg <= 1'b0;
			chromaPhase_reg <= 1'b0;
			wrAddr_reg <= '0;
			rdAddr_reg <= '0;
			scaleAcc_reg <= '0;
			lineLen_reg <= '0;
			lineState_reg <= IDLE;
			bank_reg <= '0;
			aaLuma_reg <= '0;
			prevLuma_reg <= '0;
			carrier_reg <= '0;
			hsyncDly_reg <= 1'b0;
			vsyncDly_reg <= 1'b0;
			tvLine_reg <= '0;
			lineCount_reg <= '0;
			tvPhase_reg <= 1'b0;
			comp_reg <= '0;
			luma_reg <= '0;
			chroma_reg <= '0;
			sync_reg <= 1'b0;
			burst_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			powerDown_reg <= powerDown_next;
			extClk_reg <= extClk_next;
			pix_reg <= pix_next;
			pixValid_reg <= pixValid_next;
			chromaPhase_reg <= chromaPhase_next;
			wrAddr_reg <= wrAddr_next;
			rdAddr_reg <= rdAddr_next;
			scaleAcc_reg <= scaleAcc_next;
			lineLen_reg <= lineLen_next;
			lineState_reg <= lineState_next;
			bank_reg <= bank_next;
			aaLuma_reg <= aaLuma_next;
			prevLuma_reg <= prevLuma_next;
			carrier_reg <= carrier_next;
			hsyncDly_reg <= vgaHsync;
			vsyncDly_reg <= vgaVsync;
			tvLine_reg <= tvLine_next;
			lineCount_reg <= lineCount_next;
			tvPhase_reg <= tvPhase_next;
			comp_reg <= comp_next;
			luma_reg <= luma_next;
			chroma_reg <= chroma_next;
			sync_reg <= sync_next;
			burst_reg <= burst_next;
		end
	end

	assign dacComposite = comp_reg;
	assign dacLuma = luma_reg;
	assign dacChroma = chroma_reg;
	assign tvSync = sync_reg;
	assign burstGate = burst_reg;
	assign powerDown = powerDown_reg;
	assign activeMode = mode_reg;
endmodule : tv_encoder_core
`default_nettype wire

// *** tv_encoder_core_sva.sv ***
// Purpose: assertions on mode selection, power down and tv sync outputs
// Assumes: one clock, reset asynchronous active high
// Notes: sync width checked over its first cycles only, the full width needs a counter
`timescale 1ns/1ps
`default_nettype none
module tv_encoder_core_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic programming_mode_select,
	input wire logic [2:0] display_mode_pins,
	input wire logic [2:0] serialMode,
	input wire logic serialPowerDown,
	input wire logic [7:0] dacComposite,
	input wire logic [7:0] dacLuma,
	input wire logic [7:0] dacChroma,
	input wire logic tvSync,
	input wire logic burstGate,
	input wire logic powerDown,
	input wire logic [2:0] activeMode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_pinMode;
		!programming_mode_select && display_mode_pins != 3'h7
			|=> activeMode == $past(display_mode_pins);
	endproperty
	a_pinMode: assert property (p_pinMode) else $error("pin mode not taken");
	property p_pinUp;
		!programming_mode_select && display_mode_pins != 3'h7 |=> !powerDown;
	endproperty
	a_pinUp: assert property (p_pinUp) else $error("powered down on valid pin mode");
	property p_pinDown;
		!programming_mode_select && display_mode_pins == 3'h7 |=> powerDown && $stable(activeMode);
	endproperty
	a_pinDown: assert property (p_pinDown) else $error("pin power down wrong");
	property p_serMode;
		programming_mode_select && serialMode != 3'h7 && !serialPowerDown
			|=> activeMode == $past(serialMode);
	endproperty
	a_serMode: assert property (p_serMode) else $error("serial mode not taken");
	property p_serDown;
		programming_mode_select && serialMode != 3'h7 |=> powerDown == $past(serialPowerDown);
	endproperty
	a_serDown: assert property (p_serDown) else $error("serial power down wrong");
	property p_dacOff;
		powerDown [*3] |-> dacComposite == 8'h0 && dacLuma == 8'h0 && dacChroma == 8'h0;
	endproperty
	a_dacOff: assert property (p_dacOff) else $error("dac active in power down");
	property p_burst;
		burstGate |-> !tvSync;
	endproperty
	a_burst: assert property (p_burst) else $error("burst overlaps sync");
	property p_syncWidth;
		$rose(tvSync) |-> tvSync [*8];
	endproperty
	a_syncWidth: assert property (p_syncWidth) else $error("tv sync too short");
endmodule : tv_encoder_core_sva
bind tv_encoder_core tv_encoder_core_sva chk (.clk(clk), .reset(reset),
	.programming_mode_select(programming_mode_select), .display_mode_pins(display_mode_pins),
	.serialMode(serialMode), .serialPowerDown(serialPowerDown), .dacComposite(dacComposite),
	.dacLuma(dacLuma), .dacChroma(dacChroma), .tvSync(tvSync), .burstGate(burstGate),
	.powerDown(powerDown), .activeMode(activeMode));
`default_nettype wire

// *** vga_source.sv ***
// Purpose: graphics controller model, syncs, pixel strobe and colour pixels
// Assumes: short lines and frames to keep the run small
// Notes: pixel bus changes every cycle while idle so stale data is never trusted
`timescale 1ns/1ps
`default_nettype none
module vga_source #(
	parameter int LINE_LEN = 64,
	parameter int FRAME_LINES = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	output logic hsync,
	output logic vsync,
	output logic strobe,
	output tv_encoder_pkg::rgb_s pixel
);
	logic [7:0] col_reg;
	logic [7:0] col_next;
	logic [7:0] line_reg;
	logic [7:0] line_next;
	always_comb begin
		col_next = (col_reg == 8'(LINE_LEN - 1)) ? 8'h0 : col_reg + 8'h1;
		line_next = line_reg;
		if (col_reg == 8'(LINE_LEN - 1))
			line_next = (line_reg == 8'(FRAME_LINES - 1)) ? 8'h0 : line_reg + 8'h1;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			col_reg <= 8'h0;
			line_reg <= 8'h0;
		end else begin
			col_reg <= col_next;
			line_reg <= line_next;
		end
	end
	assign hsync = run && col_reg < 8'h8;
	assign vsync = run && line_reg == 8'h0;
	assign strobe = run && col_reg[0];
	assign pixel = run ? {8'hc0, 8'h40, 8'h20} : {col_reg, ~col_reg, col_reg};
endmodule : vga_source
`default_nettype wire

// *** tb_tv_encoder_core.sv ***
// Purpose: self-checking bench for the encoder core
// Assumes: inputs change 1 ns after the rising edge
// Notes: video checks only look for activity, not for exact sample values
`timescale 1ns/1ps
`default_nettype none
module tb_tv_encoder_core;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic run = 1'b0;
	logic useExt = 1'b0;
	logic tick = 1'b0;
	logic pms = 1'b0;
	logic [2:0] pins = 3'h1;
	logic [2:0] serMode = 3'h1;
	logic serDown = 1'b0;
	logic hs, vs, stb, tvSync, burstGate, powerDown;
	logic [7:0] comp, luma, chroma;
	logic [2:0] activeMode;
	tv_encoder_pkg::rgb_s pix;
	int errors = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	always @(posedge clk) tick <= #1 ~tick;
	vga_source src (.clk(clk), .reset(reset), .run(run), .hsync(hs), .vsync(vs), .strobe(stb),
		.pixel(pix));
	tv_encoder_core dut (.clk(clk), .reset(reset), .pllPixelStrobe(stb & ~useExt),
		.external_pixel_clock_in(stb & useExt), .useExternalClock(useExt), .crystalTick(tick),
		.vgaHsync(hs), .vgaVsync(vs), .adcPixel(pix), .programming_mode_select(pms),
		.display_mode_pins(pins), .serialMode(serMode), .serialPowerDown(serDown),
		.dacComposite(comp), .dacLuma(luma), .dacChroma(chroma), .tvSync(tvSync),
		.burstGate(burstGate), .powerDown(powerDown), .activeMode(activeMode));
	task give_verdict;
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	task check_bit(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check_bit
	task check_mode(input logic [2:0] exp);
		tests_run++;
		if (activeMode !== exp) begin
			errors++;
			$display("ERROR activeMode expected %h seen %h", exp, activeMode);
		end
	endtask : check_mode
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task reset_values;
		check_mode(3'h1);
		check_bit("powerDown", 1'b0, powerDown);
		check_bit("dacLuma zero", 1'b1, luma === 8'h0);
	endtask : reset_values
	task pin_modes;
		pms = 1'b0;
		for (int m = 0; m < 7; m++) begin
			pins = 3'(m);
			step(1);
			check_mode(3'(m));
			check_bit("powerDown", 1'b0, powerDown);
		end
		pins = 3'h7;
		step(1);
		check_mode(3'h6);
		check_bit("powerDown", 1'b1, powerDown);
		step(3);
		check_bit("dac zero", 1'b1, comp === 8'h0 && luma === 8'h0 && chroma === 8'h0);
	endtask : pin_modes
	task serial_modes;
		pms = 1'b1;
		pins = 3'h7;
		for (int m = 6; m >= 0; m--) begin
			serMode = 3'(m);
			step(1);
			check_mode(3'(m));
			check_bit("powerDown", 1'b0, powerDown);
		end
		serDown = 1'b1;
		step(1);
		check_bit("powerDown", 1'b1, powerDown);
		serDown = 1'b0;
		step(1);
	endtask : serial_modes
	task video(input logic [2:0] mode, input logic ext);
		logic sawSync, sawBurst, sawLuma, sawChroma, sawComp;
		{sawSync, sawBurst, sawLuma, sawChroma, sawComp} = 5'h0;
		pms = 1'b0;
		pins = mode;
		useExt = ext;
		run = 1'b1;
		for (int i = 0; i < 3000; i++) begin
			step(1);
			sawSync |= tvSync;
			sawBurst |= burstGate;
			sawLuma |= luma != 8'h0;
			sawChroma |= chroma != 8'h0;
			sawComp |= comp != 8'h0;
		end
		check_bit("tvSync seen", 1'b1, sawSync);
		check_bit("burstGate seen", 1'b1, sawBurst);
		check_bit("dacLuma active", 1'b1, sawLuma);
		check_bit("dacChroma active", 1'b1, sawChroma);
		check_bit("dacComposite active", 1'b1, sawComp);
		run = 1'b0;
		step(4);
	endtask : video
	initial begin
		repeat (16) @(posedge clk);
		#1;
		reset_values();
		reset = 1'b0;
		step(1);
		pin_modes();
		serial_modes();
		video(3'h2, 1'b0);
		video(3'h1, 1'b1);
		video(3'h6, 1'b0);
		give_verdict();
	end
	initial begin
		#5ms;
		errors++;
		give_verdict();
	end
endmodule : tb_tv_encoder_core
`default_nettype wire
